/* rtl/actr_pkg.sv */
/*
 * Constants and types for the channel tuning register bank.
 * Assumes an APB slave with 32-bit data; each 8-bit register sits in the
 * low byte of one word whose byte address is four times its index.
 */
package actr_pkg;

    // ------------------------------------------------------------------
    // bank layout
    // ------------------------------------------------------------------
    localparam int ACTR_SLOTS = 7;

    typedef logic [2:0]  actr_slot_t;
    typedef logic [7:0]  actr_byte_t;
    typedef logic [11:0] actr_index_t;

    localparam actr_index_t IDX_DITHER_CH4  = 12'h234;
    localparam actr_index_t IDX_PERF_CH4    = 12'h239;
    localparam actr_index_t IDX_TUNE_UPPER  = 12'h308;
    localparam actr_index_t IDX_TUNE_FOUR   = 12'h31d;
    localparam actr_index_t IDX_TUNE_TWO    = 12'h41d;
    localparam actr_index_t IDX_CHOP_CH2    = 12'h422;
    localparam actr_index_t IDX_DITHER_CH2  = 12'h434;

    localparam actr_slot_t SLOT_DITHER_CH4 = 3'h0;
    localparam actr_slot_t SLOT_PERF_CH4   = 3'h1;
    localparam actr_slot_t SLOT_TUNE_UPPER = 3'h2;
    localparam actr_slot_t SLOT_TUNE_FOUR  = 3'h3;
    localparam actr_slot_t SLOT_TUNE_TWO   = 3'h4;
    localparam actr_slot_t SLOT_CHOP_CH2   = 3'h5;
    localparam actr_slot_t SLOT_DITHER_CH2 = 3'h6;

    localparam logic [ACTR_SLOTS-1:0][11:0] ACTR_IDX = {
        IDX_DITHER_CH2, IDX_CHOP_CH2, IDX_TUNE_TWO, IDX_TUNE_FOUR,
        IDX_TUNE_UPPER, IDX_PERF_CH4, IDX_DITHER_CH4};

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int POS_DITH_HI    = 5;
    localparam int POS_DITH_LO    = 3;
    localparam int POS_PERF       = 3;
    localparam int POS_TUNE_UP_HI = 7;
    localparam int POS_TUNE_UP_LO = 6;
    localparam int POS_TUNE4_HI   = 7;
    localparam int POS_TUNE4_LO   = 1;
    localparam int POS_TUNE2      = 1;
    localparam int POS_CHOP       = 1;

    // read/write field masks; all other positions are write-only
    localparam actr_byte_t MASK_DITHER  = 8'h28;
    localparam actr_byte_t MASK_PERF    = 8'h08;
    localparam actr_byte_t MASK_TUNE_UP = 8'hc0;
    localparam actr_byte_t MASK_TUNE4   = 8'h82;
    localparam actr_byte_t MASK_TUNE2   = 8'h02;
    localparam actr_byte_t MASK_CHOP    = 8'h02;

    localparam actr_byte_t RST_VALUE    = 8'h00;

    function automatic actr_byte_t actr_mask(input actr_slot_t s);
        case (s)
            SLOT_DITHER_CH4: actr_mask = MASK_DITHER;
            SLOT_PERF_CH4:   actr_mask = MASK_PERF;
            SLOT_TUNE_UPPER: actr_mask = MASK_TUNE_UP;
            SLOT_TUNE_FOUR:  actr_mask = MASK_TUNE4;
            SLOT_TUNE_TWO:   actr_mask = MASK_TUNE2;
            SLOT_CHOP_CH2:   actr_mask = MASK_CHOP;
            SLOT_DITHER_CH2: actr_mask = MASK_DITHER;
            default:         actr_mask = 8'h00;
        endcase
    endfunction

endpackage

/* rtl/actr_bank_if.sv */
/*
 * Carrier between the bus front end and the register store.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
interface actr_bank_if
    import actr_pkg::*;
();
    logic                             wr_en;
    actr_slot_t                       wr_slot;
    actr_byte_t                       wr_data;
    logic [ACTR_SLOTS-1:0][7:0]       value;

    modport ctrl  (output wr_en, output wr_slot, output wr_data,
                   input value);
    modport store (input wr_en, input wr_slot, input wr_data,
                   output value);
endinterface

/* rtl/actr_store.sv */
/*
 * Storage for the seven tuning registers.
 * Assumes one write strobe per cycle from the bus front end; only the
 * read/write field positions are kept, write-only positions drop.
 */
`timescale 1ns/10ps
module actr_store
    import actr_pkg::*;
(
    input  wire logic  i_clock,
    input  wire logic  i_rst,
    actr_bank_if.store bank
);

    // ------------------------------------------------------------------
    // one register per slot
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < ACTR_SLOTS; g++)
        begin : g_slot
            always_ff @(posedge i_clock)
            begin
                if (i_rst)
                    bank.value[g] <= RST_VALUE;
                else if (bank.wr_en && bank.wr_slot == actr_slot_t'(g))
                    bank.value[g] <= bank.wr_data &
                                     actr_mask(actr_slot_t'(g));
            end
        end
    endgenerate

endmodule // actr_store

/* rtl/actr_regs.sv */
/*
 * Channel tuning register bank with an APB slave front end.
 * Assumes a single 100 MHz clock and a synchronous reset; the global
 * dither bits arrive as inputs from logic on the same clock.
 */
`timescale 1ns/10ps
module actr_regs
    import actr_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic [1:0]        i_dither_glob_ch4,
    input  wire logic [1:0]        i_dither_glob_ch2,
    output logic                   o_dither_off_ch4,
    output logic                   o_perf_special_ch4,
    output logic [1:0]             o_high_freq_tune_upper,
    output logic [1:0]             o_high_freq_tune_four,
    output logic                   o_high_freq_tune_two,
    output logic                   o_chopper_off_ch2,
    output logic                   o_chopper_run_ch2,
    output logic                   o_dither_off_ch2
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // returns {hit, slot}; byte address is four times the index
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < ACTR_SLOTS; i++)
        begin
            if (a == ADDR_W'({ACTR_IDX[i], 2'b00}))
                r = {1'b1, 3'(i)};
        end
        return r;
    endfunction

    actr_bank_if bank ();

    logic [3:0]  dec_now;
    logic        setup_phase;
    logic        access_phase;
    logic        hit_q;
    actr_slot_t  slot_q;
    logic [31:0] prdata_q;
    logic        err_q;
    actr_byte_t  rd_byte;

    assign dec_now      = decode(i_paddr);
    assign setup_phase  = i_psel && !i_penable;
    assign access_phase = i_psel && i_penable;
    assign rd_byte      = bank.value[dec_now[2:0]] &
                          actr_mask(dec_now[2:0]);

    // ------------------------------------------------------------------
    // setup capture
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            hit_q  <= 1'b0;
            slot_q <= SLOT_DITHER_CH4;
            err_q  <= 1'b0;
        end
        else if (setup_phase)
        begin
            hit_q  <= dec_now[3];
            slot_q <= dec_now[2:0];
            err_q  <= !dec_now[3];
        end
    end

    // read data captured at setup, shown through the access phase
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            prdata_q <= 32'h0000_0000;
        else if (setup_phase)
        begin
            if (dec_now[3] && !i_pwrite)
                prdata_q <= {24'h00_0000, rd_byte};
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // bus answers and write strobe
    // ------------------------------------------------------------------
    assign o_pready  = 1'b1;
    assign o_prdata  = prdata_q;
    assign o_pslverr = access_phase && err_q;

    // writes land at the completing access edge; low lane only
    assign bank.wr_en   = access_phase && i_pwrite && hit_q && i_pstrb[0];
    assign bank.wr_slot = slot_q;
    assign bank.wr_data = i_pwdata[7:0];

    actr_store u_store (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .bank    (bank)
    );

    // ------------------------------------------------------------------
    // analog controls
    // ------------------------------------------------------------------
    actr_byte_t v_d4;
    actr_byte_t v_p4;
    actr_byte_t v_up;
    actr_byte_t v_t4;
    actr_byte_t v_t2;
    actr_byte_t v_c2;
    actr_byte_t v_d2;

    assign v_d4 = bank.value[SLOT_DITHER_CH4];
    assign v_p4 = bank.value[SLOT_PERF_CH4];
    assign v_up = bank.value[SLOT_TUNE_UPPER];
    assign v_t4 = bank.value[SLOT_TUNE_FOUR];
    assign v_t2 = bank.value[SLOT_TUNE_TWO];
    assign v_c2 = bank.value[SLOT_CHOP_CH2];
    assign v_d2 = bank.value[SLOT_DITHER_CH2];

    // dither off only when the local pair and global pair are all set
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_dither_off_ch4 <= 1'b0;
            o_dither_off_ch2 <= 1'b0;
        end
        else
        begin
            o_dither_off_ch4 <= v_d4[POS_DITH_HI] && v_d4[POS_DITH_LO] &&
                                (&i_dither_glob_ch4);
            o_dither_off_ch2 <= v_d2[POS_DITH_HI] && v_d2[POS_DITH_LO] &&
                                (&i_dither_glob_ch2);
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            o_perf_special_ch4 <= 1'b0;
        else
            o_perf_special_ch4 <= v_p4[POS_PERF];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_high_freq_tune_upper <= 2'h0;
            o_high_freq_tune_four  <= 2'h0;
            o_high_freq_tune_two   <= 1'b0;
        end
        else
        begin
            o_high_freq_tune_upper <= {v_up[POS_TUNE_UP_HI],
                                       v_up[POS_TUNE_UP_LO]};
            o_high_freq_tune_four  <= {v_t4[POS_TUNE4_HI],
                                       v_t4[POS_TUNE4_LO]};
            o_high_freq_tune_two   <= v_t2[POS_TUNE2];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_chopper_off_ch2 <= 1'b0;
            o_chopper_run_ch2 <= 1'b1;
        end
        else
        begin
            o_chopper_off_ch2 <= v_c2[POS_CHOP];
            o_chopper_run_ch2 <= !v_c2[POS_CHOP];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    dither4_on_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !v_d4[POS_DITH_HI] && !v_d4[POS_DITH_LO] |=> !o_dither_off_ch4)
        else $error("dither off with channel-4 setting 00");

    dither4_off_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        v_d4[POS_DITH_HI] && v_d4[POS_DITH_LO] && (&i_dither_glob_ch4)
        |=> o_dither_off_ch4)
        else $error("dither still on with channel-4 setting 11");

    perf_reset_a: assert property (
        @(posedge i_clock)
        i_rst |=> !v_p4[POS_PERF] && !o_perf_special_ch4)
        else $error("performance bit not zero after reset");

    perf_write_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        bank.wr_en && slot_q == SLOT_PERF_CH4
        |=> v_p4[POS_PERF] == $past(i_pwdata[POS_PERF])
            ##1 o_perf_special_ch4 == v_p4[POS_PERF])
        else $error("performance bit write not taken");

    chop_run_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !v_c2[POS_CHOP] |=> o_chopper_run_ch2 && !o_chopper_off_ch2)
        else $error("chopper stopped with disable bit clear");

    chop_off_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        v_c2[POS_CHOP] |=> o_chopper_off_ch2 && !o_chopper_run_ch2)
        else $error("chopper running with disable bit set");

    rsvd_read_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        access_phase && !i_pwrite && hit_q
        |-> (o_prdata[7:0] & ~actr_mask(slot_q)) == 8'h00 &&
            o_prdata[31:8] == 24'h00_0000)
        else $error("write-only position read back nonzero");

    rw_store_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        bank.wr_en |=> bank.value[$past(slot_q)] ==
                       ($past(i_pwdata[7:0]) & actr_mask($past(slot_q))))
        else $error("read/write field not stored");

    unmapped_err_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        setup_phase && !dec_now[3] ##1 access_phase
        |-> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    unmapped_wr_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        access_phase && i_pwrite && !hit_q |=> $stable(bank.value))
        else $error("write to unmapped address changed a register");

    strobe_drop_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        access_phase && i_pwrite && !i_pstrb[0] |=> $stable(bank.value))
        else $error("write without low strobe changed a register");

    rsvd_store_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (v_d4 & ~MASK_DITHER) == 8'h00 && (v_p4 & ~MASK_PERF) == 8'h00 &&
        (v_up & ~MASK_TUNE_UP) == 8'h00 && (v_t4 & ~MASK_TUNE4) == 8'h00 &&
        (v_t2 & ~MASK_TUNE2) == 8'h00 && (v_c2 & ~MASK_CHOP) == 8'h00 &&
        (v_d2 & ~MASK_DITHER) == 8'h00)
        else $error("write-only position held a one");

    perf_follow_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        1'b1 |=> o_perf_special_ch4 == $past(v_p4[POS_PERF]))
        else $error("performance output does not follow its bit");

    ctrl_reset_a: assert property (
        @(posedge i_clock)
        i_rst |=> o_chopper_run_ch2 && !o_chopper_off_ch2 &&
                  !o_dither_off_ch4 && !o_dither_off_ch2)
        else $error("control outputs not idle after reset");

    dither2_on_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !v_d2[POS_DITH_HI] && !v_d2[POS_DITH_LO] |=> !o_dither_off_ch2)
        else $error("dither off with channel-2 setting 00");

    dither2_off_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        v_d2[POS_DITH_HI] && v_d2[POS_DITH_LO] && (&i_dither_glob_ch2)
        |=> o_dither_off_ch2)
        else $error("dither still on with channel-2 setting 11");

    tune_follow_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        1'b1 |=> o_high_freq_tune_two == $past(v_t2[POS_TUNE2]) &&
                 o_high_freq_tune_four == $past({v_t4[POS_TUNE4_HI],
                                                 v_t4[POS_TUNE4_LO]}) &&
                 o_high_freq_tune_upper == $past({v_up[POS_TUNE_UP_HI],
                                                  v_up[POS_TUNE_UP_LO]}))
        else $error("tuning outputs do not follow their bits");

    slverr_idle_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !access_phase |-> !o_pslverr && o_pready)
        else $error("error shown outside an access phase");

endmodule // actr_regs

/* sim/actr_regs_tb_top.sv */
/*
 * Self-checking bench for the channel tuning register bank.
 * Assumes a zero-wait APB slave and control outputs that follow
 * their registers one clock later.
 */
`timescale 1ns/10ps
`define CHK(got, exp, msg) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED %0t %s", $time, msg); \
        end \
    end
module actr_regs_tb_top;
    import actr_pkg::*;

    logic              i_clock = 1'b0;
    logic              i_rst = 1'b1;
    logic              i_psel = 1'b0;
    logic              i_penable = 1'b0;
    logic              i_pwrite = 1'b0;
    logic [15:0]       i_paddr = 16'h0000;
    logic [31:0]       i_pwdata = 32'h0;
    logic [3:0]        i_pstrb = 4'h0;
    logic [1:0]        i_dither_glob_ch4 = 2'h0;
    logic [1:0]        i_dither_glob_ch2 = 2'h0;
    logic [31:0]       o_prdata;
    logic              o_pready;
    logic              o_pslverr;
    logic [11:0]       ctrl;
    logic [31:0]       rdat;
    logic              rerr;
    integer            seed = 32'hcad1fa7f;
    int                fail_count = 0;
    int                checks = 0;
    actr_byte_t        model [ACTR_SLOTS];
    actr_byte_t        mask [ACTR_SLOTS] = '{MASK_DITHER, MASK_PERF,
        MASK_TUNE_UP, MASK_TUNE4, MASK_TUNE2, MASK_CHOP, MASK_DITHER};

    actr_regs #(.ADDR_W(16)) u_actr_regs (
        .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_dither_glob_ch4(i_dither_glob_ch4),
        .i_dither_glob_ch2(i_dither_glob_ch2),
        .o_dither_off_ch4(ctrl[11]), .o_perf_special_ch4(ctrl[10]),
        .o_high_freq_tune_upper(ctrl[9:8]),
        .o_high_freq_tune_four(ctrl[7:6]), .o_high_freq_tune_two(ctrl[5]),
        .o_chopper_off_ch2(ctrl[4]), .o_chopper_run_ch2(ctrl[3]),
        .o_dither_off_ch2(ctrl[2]));
    assign ctrl[1:0] = 2'b00;

    initial
    begin
        forever #5 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic [15:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        i_pstrb <= s;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (o_pready !== 1'b1);
        rdat = o_prdata;
        rerr = o_pslverr;
        `CHK(n, 1, "wait states")
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    function automatic logic [15:0] adr(input int s);
        adr = {2'b00, ACTR_IDX[s], 2'b00};
    endfunction

    task automatic wr(input int s, input logic [7:0] d, input logic [3:0] st);
        apb(adr(s), 1'b1, {24'h0, d}, st);
        `CHK(rerr, 1'b0, "write error")
        if (st[0])
            model[s] = d & mask[s];
    endtask

    task automatic rd_chk(input int s);
        apb(adr(s), 1'b0, 32'h0, 4'h0);
        `CHK({rerr, rdat}, {9'h0, 16'h0, model[s]}, "read back")
    endtask

    function automatic logic [11:0] exp_ctrl();
        actr_byte_t m4;
        actr_byte_t m2;
        m4 = model[SLOT_DITHER_CH4];
        m2 = model[SLOT_DITHER_CH2];
        exp_ctrl = {m4[5] & m4[3] & (&i_dither_glob_ch4),
            model[SLOT_PERF_CH4][3], model[SLOT_TUNE_UPPER][7:6],
            model[SLOT_TUNE_FOUR][7], model[SLOT_TUNE_FOUR][1],
            model[SLOT_TUNE_TWO][1], model[SLOT_CHOP_CH2][1],
            ~model[SLOT_CHOP_CH2][1], m2[5] & m2[3] & (&i_dither_glob_ch2),
            2'b00};
    endfunction

    task automatic chk_ctrl();
        repeat (2) @(negedge i_clock);
        `CHK(ctrl, exp_ctrl(), "control outputs")
    endtask

    task automatic do_reset();
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        for (int s = 0; s < ACTR_SLOTS; s++)
            model[s] = RST_VALUE;
        for (int s = 0; s < ACTR_SLOTS; s++)
            rd_chk(s);
        chk_ctrl();
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial
    begin
        do_reset();
        wr(SLOT_PERF_CH4, 8'h08, 4'h1);
        chk_ctrl();
        for (int k = 0; k < 8; k++)
        begin
            @(posedge i_clock);
            i_dither_glob_ch4 <= k[1:0];
            i_dither_glob_ch2 <= ~k[1:0];
            wr(SLOT_DITHER_CH4, k[2] ? 8'h28 : 8'h08, 4'h1);
            wr(SLOT_DITHER_CH2, k[2] ? 8'h28 : 8'h20, 4'h1);
            chk_ctrl();
        end
        wr(SLOT_CHOP_CH2, 8'h02, 4'h1);
        chk_ctrl();
        wr(SLOT_CHOP_CH2, 8'h00, 4'h1);
        chk_ctrl();
        for (int s = SLOT_TUNE_UPPER; s <= SLOT_TUNE_TWO; s++)
            wr(s, mask[s], 4'h1);
        chk_ctrl();
        wr(SLOT_TUNE_TWO, 8'h00, 4'he);
        rd_chk(SLOT_TUNE_TWO);
        apb(16'h0004, 1'b1, 32'hff, 4'hf);
        `CHK(rerr, 1'b1, "unmapped write")
        apb(16'h08d1, 1'b0, 32'h0, 4'h0);
        `CHK({rerr, rdat}, {1'b1, 32'h0}, "misaligned read")
        for (int s = 0; s < ACTR_SLOTS; s++)
            rd_chk(s);
        for (int i = 0; i < 60; i++)
        begin
            int s;
            s = {$random(seed)} % ACTR_SLOTS;
            @(posedge i_clock);
            i_dither_glob_ch4 <= 2'($random(seed));
            i_dither_glob_ch2 <= 2'($random(seed));
            wr(s, 8'($random(seed)) & mask[s], 4'($random(seed)));
            rd_chk(s);
            chk_ctrl();
        end
        do_reset();
        conclude();
    end

    initial
    begin
        repeat (8000) @(posedge i_clock);
        fail_count++;
        conclude();
    end

endmodule // actr_regs_tb_top
